// ===== rtl/ipapm_consts.vh
// Register map, field positions and fixed codes of the interrupt controller
`ifndef IPAPM_CONSTS_VH
`define IPAPM_CONSTS_VH

`define IPAPM_ADDR_ENABLE 8'ha8
`define IPAPM_ADDR_PRIO 8'hb8
`define IPAPM_ADDR_POWER 8'h80
`define IPAPM_ADDR_FLAGS 8'h84
`define IPAPM_ADDR_STATUS 8'h88
`define IPAPM_ADDR_EDGE 8'h8c

`define IPAPM_EN_GLOBAL 7
`define IPAPM_EN_MASK 8'h8f
`define IPAPM_SRC_MSB 3
`define IPAPM_PWR_IDLE 0
`define IPAPM_PWR_DOWN 1
`define IPAPM_PWR_SLOW 5

`define IPAPM_SRC_EXT_A 0
`define IPAPM_SRC_EXT_B 2
`define IPAPM_SRC_TMR_A 1
`define IPAPM_SRC_TMR_B 3
`define IPAPM_EDGE_A 0
`define IPAPM_EDGE_B 1

`define IPAPM_VEC_EXT_A 16'h0003
`define IPAPM_VEC_TMR_A 16'h000b
`define IPAPM_VEC_EXT_B 16'h0013
`define IPAPM_VEC_TMR_B 16'h001b

`define IPAPM_RESP_OKAY 2'h0
`define IPAPM_RESP_DECERR 2'h3

`define IPAPM_SETTLE_DEFAULT 16'h03e8

`endif

// ===== rtl/ipapm_sync.v
// Three-stage pin synchroniser; output moves once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module ipapm_sync #(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] pinIn,
	output reg [WIDTH-1:0] pinOut_q
);
	reg [WIDTH-1:0] stage1_q;
	reg [WIDTH-1:0] stage2_q;
	reg [WIDTH-1:0] stage3_q;
	integer i;

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			stage1_q <= INIT;
			stage2_q <= INIT;
			stage3_q <= INIT;
			pinOut_q <= INIT;
		end else begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (stage2_q[i] == stage3_q[i]) begin
					pinOut_q[i] <= stage3_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ipapm_resolve.v
// Two-level priority resolver with fixed order inside each level
`timescale 1ns/100ps
`default_nettype none
module ipapm_resolve (
	input wire [3:0] req,
	input wire [3:0] highSel,
	input wire inProgHigh,
	input wire inProgLow,
	output reg grant,
	output reg [1:0] grantIdx,
	output reg grantHigh
);
	wire [3:0] highReq;
	wire [3:0] lowReq;

	assign highReq = req & highSel;
	assign lowReq = req & ~highSel;

	// Lowest index wins: ext A, timer A, ext B, timer B
	function [1:0] firstIdx;
		input [3:0] r;
		begin
			if (r[0]) firstIdx = 2'h0;
			else if (r[1]) firstIdx = 2'h1;
			else if (r[2]) firstIdx = 2'h2;
			else firstIdx = 2'h3;
		end
	endfunction

	always @* begin
		grant = 1'b0;
		grantIdx = 2'h0;
		grantHigh = 1'b0;
		if (inProgHigh) begin
			grant = 1'b0;
		end else if (|highReq) begin
			grant = 1'b1;
			grantIdx = firstIdx(highReq);
			grantHigh = 1'b1;
		end else if (!inProgLow && |lowReq) begin
			grant = 1'b1;
			grantIdx = firstIdx(lowReq);
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ipapm_ctrl.v
// Interrupt priority controller with idle and power-down control
`timescale 1ns/100ps
`default_nettype none
`include "ipapm_consts.vh"
module ipapm_ctrl #(
	parameter [15:0] SETTLE_CYCLES = `IPAPM_SETTLE_DEFAULT
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire extRequestA_n,
	input wire extRequestB_n,
	input wire timerAOverflow,
	input wire timerBOverflow,
	input wire flagSampleState,
	input wire pollCycle,
	input wire lastCycle,
	input wire instrHoldoff,
	input wire returnFromService,
	output reg hardwareVectorCall_q,
	output reg [15:0] vectorAddr_q,
	output reg inProgHigh_q,
	output reg inProgLow_q,
	output reg cpuRun_q,
	output reg mainOscRun_q,
	output reg slowOscRun_q,
	output reg periphRun_q,
	output reg portsHigh_q,
	output reg coreReset_q
);
	////////////////////////////////////////////////////////////////////////
	// State
	reg [7:0] enable_q;
	reg [3:0] prioSel_q;
	reg [3:0] flags_q;
	reg [3:0] flags_d;
	reg [1:0] edgeSel_q;
	reg keepSlowOsc_q;
	reg idle_q;
	reg powerDown_q;
	reg settling_q;
	reg [15:0] settleCnt_q;
	reg [3:0] sample_q;
	reg sampleValid_q;
	reg busHoldoff_q;
	reg extAPrev_q;
	reg extBPrev_q;
	reg [7:0] awAddr_q;
	reg awHeld_q;
	reg [7:0] wByte_q;
	reg wLaneOn_q;
	reg wHeld_q;

	wire [1:0] extSync;
	wire extALow;
	wire extBLow;
	wire grant;
	wire [1:0] grantIdx;
	wire grantHigh;
	wire [3:0] enabledReq;
	wire callNow;
	wire doWrite;
	wire anyEnabled;
	wire wakePd;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and priority resolution
	ipapm_sync #(
		.WIDTH(2),
		.INIT(2'h3)
	) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pinIn({extRequestB_n, extRequestA_n}),
		.pinOut_q(extSync)
	);

	assign extALow = ~extSync[0];
	assign extBLow = ~extSync[1];

	ipapm_resolve u_resolve (
		.req(sample_q),
		.highSel(prioSel_q),
		.inProgHigh(inProgHigh_q),
		.inProgLow(inProgLow_q),
		.grant(grant),
		.grantIdx(grantIdx),
		.grantHigh(grantHigh)
	);

	// Each source gated by its own bit and the global gate
	assign enabledReq = flags_q & enable_q[`IPAPM_SRC_MSB:0] &
		{4{enable_q[`IPAPM_EN_GLOBAL]}};
	assign anyEnabled = |enabledReq;

	assign callNow = pollCycle & sampleValid_q & grant & lastCycle &
		~instrHoldoff & ~busHoldoff_q;

	// Only level-mode, enabled external requests can end power-down
	assign wakePd = (enabledReq[`IPAPM_SRC_EXT_A] &
		~edgeSel_q[`IPAPM_EDGE_A]) |
		(enabledReq[`IPAPM_SRC_EXT_B] & ~edgeSel_q[`IPAPM_EDGE_B]);

	assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

	function [15:0] vectorOf;
		input [1:0] idx;
		begin
			case (idx)
				2'h0: vectorOf = `IPAPM_VEC_EXT_A;
				2'h1: vectorOf = `IPAPM_VEC_TMR_A;
				2'h2: vectorOf = `IPAPM_VEC_EXT_B;
				default: vectorOf = `IPAPM_VEC_TMR_B;
			endcase
		end
	endfunction

	function wrHit;
		input [7:0] addr;
		input [7:0] target;
		begin
			wrHit = (addr == target);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Request flags: hardware set wins over any clear in the same cycle
	always @* begin
		flags_d = flags_q;
		if (doWrite && wLaneOn_q && wrHit(awAddr_q, `IPAPM_ADDR_FLAGS)) begin
			flags_d = wByte_q[`IPAPM_SRC_MSB:0];
		end
		if (callNow) begin
			flags_d[grantIdx] = 1'b0;
		end
		if (edgeSel_q[`IPAPM_EDGE_A]) begin
			if (extALow && !extAPrev_q) begin
				flags_d[`IPAPM_SRC_EXT_A] = 1'b1;
			end
		end else begin
			// Level mode follows the pin; source must release before return
			flags_d[`IPAPM_SRC_EXT_A] = extALow;
		end
		if (edgeSel_q[`IPAPM_EDGE_B]) begin
			if (extBLow && !extBPrev_q) begin
				flags_d[`IPAPM_SRC_EXT_B] = 1'b1;
			end
		end else begin
			flags_d[`IPAPM_SRC_EXT_B] = extBLow;
		end
		if (timerAOverflow) begin
			flags_d[`IPAPM_SRC_TMR_A] = 1'b1;
		end
		if (timerBOverflow) begin
			flags_d[`IPAPM_SRC_TMR_B] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sampling, polling, vectoring and return
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			flags_q <= 4'h0;
			extAPrev_q <= 1'b0;
			extBPrev_q <= 1'b0;
			sample_q <= 4'h0;
			sampleValid_q <= 1'b0;
			busHoldoff_q <= 1'b0;
			hardwareVectorCall_q <= 1'b0;
			vectorAddr_q <= 16'h0000;
			inProgHigh_q <= 1'b0;
			inProgLow_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			extAPrev_q <= extALow;
			extBPrev_q <= extBLow;
			if (flagSampleState) begin
				sample_q <= enabledReq;
				sampleValid_q <= 1'b1;
			end else if (pollCycle) begin
				sampleValid_q <= 1'b0;
			end
			// A bus write to enable or priority defers the next call
			if (doWrite && (wrHit(awAddr_q, `IPAPM_ADDR_ENABLE) ||
				wrHit(awAddr_q, `IPAPM_ADDR_PRIO))) begin
				busHoldoff_q <= 1'b1;
			end else if (pollCycle && lastCycle) begin
				busHoldoff_q <= 1'b0;
			end
			hardwareVectorCall_q <= callNow;
			if (callNow) begin
				vectorAddr_q <= vectorOf(grantIdx);
				if (grantHigh) begin
					inProgHigh_q <= 1'b1;
				end else begin
					inProgLow_q <= 1'b1;
				end
			end else if (returnFromService) begin
				// Only this return clears progress; a plain return never does
				if (inProgHigh_q) begin
					inProgHigh_q <= 1'b0;
				end else begin
					inProgLow_q <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Idle, power-down and reset outputs
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			idle_q <= 1'b0;
			powerDown_q <= 1'b0;
			settling_q <= 1'b0;
			settleCnt_q <= 16'h0000;
			cpuRun_q <= 1'b0;
			mainOscRun_q <= 1'b1;
			slowOscRun_q <= 1'b1;
			periphRun_q <= 1'b0;
			portsHigh_q <= 1'b1;
			coreReset_q <= 1'b1;
		end else begin
			portsHigh_q <= 1'b0;
			coreReset_q <= 1'b0;
			if (doWrite && wLaneOn_q && wrHit(awAddr_q, `IPAPM_ADDR_POWER)) begin
				idle_q <= wByte_q[`IPAPM_PWR_IDLE];
				powerDown_q <= wByte_q[`IPAPM_PWR_DOWN];
			end else if (powerDown_q && wakePd) begin
				powerDown_q <= 1'b0;
				idle_q <= 1'b0;
				settling_q <= 1'b1;
				settleCnt_q <= SETTLE_CYCLES;
			end else if (idle_q && !powerDown_q && anyEnabled) begin
				idle_q <= 1'b0;
			end
			// Restarted oscillator is given time before the core runs again
			if (settling_q) begin
				if (settleCnt_q == 16'h0000) begin
					settling_q <= 1'b0;
				end else begin
					settleCnt_q <= settleCnt_q - 16'h0001;
				end
			end
			cpuRun_q <= ~idle_q & ~powerDown_q & ~settling_q;
			mainOscRun_q <= ~powerDown_q;
			slowOscRun_q <= ~powerDown_q | keepSlowOsc_q;
			periphRun_q <= ~powerDown_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			enable_q <= 8'h00;
			prioSel_q <= 4'h0;
			edgeSel_q <= 2'h0;
			keepSlowOsc_q <= 1'b0;
		end else if (doWrite && wLaneOn_q) begin
			case (awAddr_q)
				`IPAPM_ADDR_ENABLE: begin
					enable_q <= wByte_q & `IPAPM_EN_MASK;
				end
				`IPAPM_ADDR_PRIO: begin
					// Reserved upper bits are not stored
					prioSel_q <= wByte_q[`IPAPM_SRC_MSB:0];
				end
				`IPAPM_ADDR_EDGE: begin
					edgeSel_q <= wByte_q[`IPAPM_EDGE_B:0];
				end
				`IPAPM_ADDR_POWER: begin
					keepSlowOsc_q <= wByte_q[`IPAPM_PWR_SLOW];
				end
				default: begin
					enable_q <= enable_q;
				end
			endcase
		end
	end

	function wrValid;
		input [7:0] addr;
		begin
			wrValid = (addr == `IPAPM_ADDR_ENABLE) ||
				(addr == `IPAPM_ADDR_PRIO) ||
				(addr == `IPAPM_ADDR_POWER) ||
				(addr == `IPAPM_ADDR_FLAGS) ||
				(addr == `IPAPM_ADDR_STATUS) ||
				(addr == `IPAPM_ADDR_EDGE);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IPAPM_RESP_OKAY;
			awHeld_q <= 1'b0;
			awAddr_q <= 8'h00;
			wHeld_q <= 1'b0;
			wByte_q <= 8'h00;
			wLaneOn_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wByte_q <= s_axi_wdata[7:0];
				wLaneOn_q <= s_axi_wstrb[0];
				wHeld_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrValid(awAddr_q) ? `IPAPM_RESP_OKAY :
					`IPAPM_RESP_DECERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IPAPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `IPAPM_RESP_OKAY;
			case (s_axi_araddr)
				`IPAPM_ADDR_ENABLE: s_axi_rdata <= {24'h000000, enable_q};
				`IPAPM_ADDR_PRIO: s_axi_rdata <= {28'h0000000, prioSel_q};
				`IPAPM_ADDR_POWER: s_axi_rdata <= {26'h0, keepSlowOsc_q,
					3'h0, powerDown_q, idle_q};
				`IPAPM_ADDR_FLAGS: s_axi_rdata <= {28'h0000000, flags_q};
				`IPAPM_ADDR_STATUS: s_axi_rdata <= {27'h0, settling_q,
					sampleValid_q, busHoldoff_q, inProgHigh_q, inProgLow_q};
				`IPAPM_ADDR_EDGE: s_axi_rdata <= {30'h0, edgeSel_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `IPAPM_RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== sim/ipapm_monitor.sv
// Port checker for the interrupt priority controller
`timescale 1ns/100ps
`default_nettype none
`include "ipapm_consts.vh"
module ipapm_monitor (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pollCycle,
	input wire logic lastCycle,
	input wire logic instrHoldoff,
	input wire logic returnFromService,
	input wire logic hardwareVectorCall_q,
	input wire logic [15:0] vectorAddr_q,
	input wire logic inProgHigh_q,
	input wire logic inProgLow_q,
	input wire logic cpuRun_q,
	input wire logic mainOscRun_q,
	input wire logic periphRun_q,
	input wire logic portsHigh_q,
	input wire logic coreReset_q
);
////////////////////////////////////////////////////////////
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
sequence pollOk;
	pollCycle && lastCycle && !instrHoldoff;
endsequence
sequence retHigh;
	returnFromService && inProgHigh_q;
endsequence
////////////////////////////////////////////////////////////
call_pulse_a: assert property (hardwareVectorCall_q |=>
	!hardwareVectorCall_q) else $error("call longer than one cycle");
call_at_poll_a: assert property (hardwareVectorCall_q |->
	$past(pollCycle) && $past(lastCycle) && !$past(instrHoldoff))
	else $error("call without a qualified poll");
vec_legal_a: assert property (hardwareVectorCall_q |-> vectorAddr_q
	inside {`IPAPM_VEC_EXT_A, `IPAPM_VEC_TMR_A, `IPAPM_VEC_EXT_B,
	`IPAPM_VEC_TMR_B}) else $error("illegal vector");
vec_hold_a: assert property (!hardwareVectorCall_q |->
	$stable(vectorAddr_q)) else $error("vector moved without call");
high_blocks_a: assert property (hardwareVectorCall_q |->
	!$past(inProgHigh_q)) else $error("call during high routine");
low_preempt_a: assert property (hardwareVectorCall_q &&
	$past(inProgLow_q) |-> inProgHigh_q) else $error("low preempted low");
call_marks_a: assert property (hardwareVectorCall_q |->
	inProgHigh_q || inProgLow_q) else $error("call left no level busy");
ret_high_a: assert property (retHigh |=> !inProgHigh_q)
	else $error("return kept high level busy");
reset_ports_a: assert property ($fell(sys_rst) |->
	portsHigh_q && coreReset_q ##1 !portsHigh_q)
	else $error("ports not high through reset");
pd_clock_a: assert property (!mainOscRun_q |->
	!cpuRun_q && !periphRun_q) else $error("clock stopped but running");
call_seen_c: cover property (pollOk ##1 hardwareVectorCall_q);
endmodule
bind ipapm_ctrl ipapm_monitor ipapm_monitor_i (.sys_clk, .sys_rst,
	.pollCycle, .lastCycle, .instrHoldoff, .returnFromService,
	.hardwareVectorCall_q, .vectorAddr_q, .inProgHigh_q, .inProgLow_q,
	.cpuRun_q, .mainOscRun_q, .periphRun_q, .portsHigh_q, .coreReset_q);
`default_nettype wire

// ===== sim/ipapm_core_model.sv
// Core side model: machine-cycle strobes, returns and call bookkeeping
`timescale 1ns/100ps
`default_nettype none
module ipapm_core_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cpuRun_q,
	input wire logic hardwareVectorCall_q,
	input wire logic [15:0] vectorAddr_q,
	input wire logic lastEn,
	input wire logic holdEn,
	input wire logic retReq,
	output logic flagSampleState,
	output logic pollCycle,
	output logic lastCycle,
	output logic instrHoldoff,
	output logic returnFromService,
	output logic [31:0] callCount,
	output logic [15:0] lastVec
);
////////////////////////////////////////////////////////////
logic [1:0] phase_q;
// Strobes freeze while the processor is halted, as a stopped core would
always @(posedge sys_clk) begin
	if (sys_rst) begin
		phase_q <= 2'h0;
		{flagSampleState, pollCycle, lastCycle} <= 3'h0;
		{instrHoldoff, returnFromService} <= 2'h0;
		callCount <= 32'h0;
		lastVec <= 16'h0;
	end else begin
		if (cpuRun_q) phase_q <= phase_q + 2'h1;
		flagSampleState <= cpuRun_q && phase_q == 2'h0;
		pollCycle <= cpuRun_q && phase_q == 2'h2;
		lastCycle <= lastEn;
		returnFromService <= retReq;
		// Return holds off vectoring until one more poll has passed
		instrHoldoff <= holdEn | retReq | (instrHoldoff & ~pollCycle);
		if (hardwareVectorCall_q) begin
			callCount <= callCount + 32'h1;
			lastVec <= vectorAddr_q;
		end
	end
end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the interrupt priority controller
`timescale 1ns/100ps
`default_nettype none
`include "ipapm_consts.vh"
module tb;
logic sys_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, callCount;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic extRequestA_n, extRequestB_n, timerAOverflow, timerBOverflow;
logic flagSampleState, pollCycle, lastCycle, instrHoldoff;
logic returnFromService, hardwareVectorCall_q, inProgHigh_q, inProgLow_q;
logic cpuRun_q, mainOscRun_q, slowOscRun_q, periphRun_q, portsHigh_q;
logic coreReset_q, lastEn, holdEn, retReq;
logic [15:0] vectorAddr_q, lastVec;
int n_errors, checks_done;
logic [1:0] wrResp;
ipapm_ctrl #(.SETTLE_CYCLES(16'h0004)) ipapm_ctrl_i (.sys_clk, .sys_rst,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.extRequestA_n, .extRequestB_n, .timerAOverflow, .timerBOverflow,
	.flagSampleState, .pollCycle, .lastCycle, .instrHoldoff,
	.returnFromService, .hardwareVectorCall_q, .vectorAddr_q,
	.inProgHigh_q, .inProgLow_q, .cpuRun_q, .mainOscRun_q, .slowOscRun_q,
	.periphRun_q, .portsHigh_q, .coreReset_q);
ipapm_core_model ipapm_core_model_i (.sys_clk, .sys_rst, .cpuRun_q,
	.hardwareVectorCall_q, .vectorAddr_q, .lastEn, .holdEn, .retReq,
	.flagSampleState, .pollCycle, .lastCycle, .instrHoldoff,
	.returnFromService, .callCount, .lastVec);
////////////////////////////////////////////////////////////
initial begin
	sys_clk = 1'b0;
	forever #50 sys_clk = ~sys_clk;
end
task end_sim;
	$display("checks %0d errors %0d", checks_done, n_errors);
	if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
	checks_done++;
	if (g !== e) begin
		n_errors++;
		$display("ERROR %0t got %h exp %h", $time, g, e);
	end
endtask
task chkb(input logic g, input logic e);
	chk({31'h0, g}, {31'h0, e});
endtask
////////////////////////////////////////////////////////////
task wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge sys_clk);
	s_axi_awaddr <= a;
	s_axi_wdata <= {24'h0, d};
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
	do begin
		@(posedge sys_clk);
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
	end while (!s_axi_bvalid);
	s_axi_bready <= 1'b0;
	chk({30'h0, s_axi_bresp}, {30'h0, wrResp});
endtask
task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
	@(posedge sys_clk);
	s_axi_araddr <= a;
	{s_axi_arvalid, s_axi_rready} <= 2'h3;
	do begin
		@(posedge sys_clk);
		if (s_axi_arready) s_axi_arvalid <= 1'b0;
	end while (!s_axi_rvalid);
	s_axi_rready <= 1'b0;
	chk(s_axi_rdata, e);
	chk({30'h0, s_axi_rresp}, {30'h0, r});
endtask
task tmr(input logic [1:0] m);
	@(posedge sys_clk);
	{timerBOverflow, timerAOverflow} <= m;
	@(posedge sys_clk);
	{timerBOverflow, timerAOverflow} <= 2'h0;
endtask
// Bounded wait for the next call, then the vector it carried
task call(input logic [15:0] v);
	logic [31:0] n;
	int t;
	n = callCount;
	t = 0;
	while (callCount === n && t < 60) begin
		@(posedge sys_clk);
		t++;
	end
	chk(callCount, n + 32'h1);
	chk({16'h0, lastVec}, {16'h0, v});
endtask
task none;
	logic [31:0] n;
	n = callCount;
	repeat (24) @(posedge sys_clk);
	chk(callCount, n);
endtask
task return_from_service;
	@(posedge sys_clk);
	retReq <= 1'b1;
	@(posedge sys_clk);
	retReq <= 1'b0;
	repeat (2) @(posedge sys_clk);
endtask
////////////////////////////////////////////////////////////
task t_order;
	rchk(8'h10, 32'h0, `IPAPM_RESP_DECERR);
	wr(`IPAPM_ADDR_PRIO, 8'h0f);
	rchk(`IPAPM_ADDR_PRIO, 32'h0000000f, `IPAPM_RESP_OKAY);
	// Lane zero off: the write is answered but must not land
	s_axi_wstrb <= 4'h0;
	wr(`IPAPM_ADDR_PRIO, 8'h00);
	s_axi_wstrb <= 4'hf;
	rchk(`IPAPM_ADDR_PRIO, 32'h0000000f, `IPAPM_RESP_OKAY);
	wrResp = `IPAPM_RESP_DECERR;
	wr(8'h10, 8'hff);
	wrResp = `IPAPM_RESP_OKAY;
	wr(`IPAPM_ADDR_PRIO, 8'h00);
	wr(`IPAPM_ADDR_ENABLE, 8'h8f);
	tmr(2'h3);
	call(`IPAPM_VEC_TMR_A);
	return_from_service;
	call(`IPAPM_VEC_TMR_B);
	return_from_service;
	$display("t_order done");
endtask
task t_level;
	wr(`IPAPM_ADDR_PRIO, 8'h08);
	tmr(2'h3);
	call(`IPAPM_VEC_TMR_B);
	chkb(inProgHigh_q, 1'b1);
	none;
	return_from_service;
	chkb(inProgHigh_q, 1'b0);
	call(`IPAPM_VEC_TMR_A);
	tmr(2'h3);
	call(`IPAPM_VEC_TMR_B);
	return_from_service;
	none;
	chkb(inProgLow_q, 1'b1);
	return_from_service;
	call(`IPAPM_VEC_TMR_A);
	return_from_service;
	wr(`IPAPM_ADDR_PRIO, 8'h00);
	$display("t_level done");
endtask
task t_block;
	wr(`IPAPM_ADDR_ENABLE, 8'h0f);
	tmr(2'h1);
	none;
	wr(`IPAPM_ADDR_FLAGS, 8'h00);
	wr(`IPAPM_ADDR_ENABLE, 8'h8f);
	none;
	lastEn <= 1'b0;
	tmr(2'h1);
	none;
	{lastEn, holdEn} <= 2'h3;
	none;
	holdEn <= 1'b0;
	call(`IPAPM_VEC_TMR_A);
	return_from_service;
	$display("t_block done");
endtask
task t_ext;
	wr(`IPAPM_ADDR_EDGE, 8'h01);
	wr(`IPAPM_ADDR_ENABLE, 8'h85);
	{extRequestA_n, extRequestB_n} <= 2'h0;
	repeat (6) @(posedge sys_clk);
	extRequestA_n <= 1'b1;
	call(`IPAPM_VEC_EXT_A);
	rchk(`IPAPM_ADDR_FLAGS, 32'h00000004, `IPAPM_RESP_OKAY);
	return_from_service;
	call(`IPAPM_VEC_EXT_B);
	extRequestB_n <= 1'b1;
	repeat (6) @(posedge sys_clk);
	return_from_service;
	none;
	$display("t_ext done");
endtask
task t_power;
	int t;
	wr(`IPAPM_ADDR_EDGE, 8'h00);
	wr(`IPAPM_ADDR_ENABLE, 8'h83);
	wr(`IPAPM_ADDR_POWER, 8'h01);
	repeat (2) @(posedge sys_clk);
	chkb(cpuRun_q, 1'b0);
	chkb(periphRun_q, 1'b1);
	tmr(2'h1);
	call(`IPAPM_VEC_TMR_A);
	return_from_service;
	wr(`IPAPM_ADDR_POWER, 8'h22);
	repeat (2) @(posedge sys_clk);
	chkb(mainOscRun_q, 1'b0);
	chkb(slowOscRun_q, 1'b1);
	extRequestA_n <= 1'b0;
	t = 0;
	while (cpuRun_q !== 1'b1 && t < 60) begin
		@(posedge sys_clk);
		t++;
	end
	chkb(cpuRun_q, 1'b1);
	chkb(portsHigh_q, 1'b0);
	call(`IPAPM_VEC_EXT_A);
	extRequestA_n <= 1'b1;
	repeat (6) @(posedge sys_clk);
	return_from_service;
	$display("t_power done");
endtask
task t_reset;
	wr(`IPAPM_ADDR_POWER, 8'h02);
	repeat (2) @(posedge sys_clk);
	chkb(slowOscRun_q, 1'b0);
	chkb(cpuRun_q, 1'b0);
	sys_rst <= 1'b1;
	// 36 us at the 100 ns clock
	repeat (360) @(posedge sys_clk);
	chkb(portsHigh_q, 1'b1);
	chkb(coreReset_q, 1'b1);
	sys_rst <= 1'b0;
	repeat (2) @(posedge sys_clk);
	chkb(cpuRun_q, 1'b1);
	chkb(coreReset_q, 1'b0);
	rchk(`IPAPM_ADDR_POWER, 32'h00000000, `IPAPM_RESP_OKAY);
	$display("t_reset done");
endtask
////////////////////////////////////////////////////////////
initial begin
	sys_rst = 1'b1;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
	{s_axi_arvalid, s_axi_rready, timerAOverflow, timerBOverflow} = 4'h0;
	{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	s_axi_wstrb = 4'hf;
	wrResp = `IPAPM_RESP_OKAY;
	{extRequestA_n, extRequestB_n, lastEn, holdEn, retReq} = 5'h1c;
	repeat (16) @(posedge sys_clk);
	chkb(portsHigh_q, 1'b1);
	sys_rst <= 1'b0;
	t_order;
	t_level;
	t_block;
	t_ext;
	t_power;
	t_reset;
	end_sim;
end
// Whole run needs under a thousand cycles; a hang stops well after that
initial begin
	repeat (20000) @(posedge sys_clk);
	n_errors++;
	end_sim;
end
endmodule
`default_nettype wire
